// >>> hdl/dorpc_pkg.sv
// Constants and carrier types for the dynamic memory controller
package dorpc_pkg;
    // ------------------------------------------------------------
    // Organisation
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int HALF_W = 6;
    localparam int NUM_ROWS = 64;
    localparam int PAGE_COLS = 64;
    localparam int WARM_CYCLES = 8;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int REFRESH_PERIOD_MS = 2;
    localparam int REFRESH_CYC = REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // Per-row refresh spacing, rounded down, with margin of one row
    localparam int ROW_GAP_CYC = REFRESH_CYC / (NUM_ROWS + 1);
    localparam int ACCESS_NS = 250;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE_CYC = 6;
    localparam logic [7:0] PHASE_LAST = 8'h05;
    localparam logic [7:0] ACC_LAST = 8'h0D;
    // Refresh phase: row strobe low for eight cycles, then recovery
    localparam logic [7:0] REF_LAST = 8'h0B;
    localparam logic [5:0] ROW_LAST = 6'h3F;
    localparam logic [3:0] WARM_LAST = 4'h7;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic sel;
        logic page;
        logic [ADDR_W-1:0] addr;
        logic wdata;
    } dorpc_req_type;
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cs_n;
        logic [HALF_W-1:0] addr;
        logic din;
    } dorpc_pins_type;
endpackage : dorpc_pkg

// >>> hdl/dorpc_count.sv
// Small terminal counter with restart
`timescale 1ns/10ps
`default_nettype none
module dorpc_count #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_en,
    input wire logic [W-1:0] i_last,
    output logic o_done,
    output logic [W-1:0] o_cnt
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    // Next count
    always_comb begin
        cnt_d = cnt_q;
        if (i_clr) begin
            cnt_d = '0;
        end else if (i_en && (cnt_q != i_last)) begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
    // Count register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign o_done = (cnt_q == i_last);
    assign o_cnt = cnt_q;
endmodule : dorpc_count
`default_nettype wire

// >>> hdl/dorpc_ctrl.sv
// Strobe sequencer for a 4096 x 1 dynamic memory
// Function
// - All 64 rows refreshed every 2 ms
// - Refresh keeps chip select inactive
// - Refresh holds column strobe high
// - Column strobe reaches all chips
// - Page mode holds row, up to 64 columns
// - Eight refresh cycles after power-up first
// - Fault forces row strobe, data inactive
// - Row then column halves on six lines
// - Write held high through read column
`timescale 1ns/10ps
`default_nettype none
module dorpc_ctrl
    import dorpc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_REQ_VALID,
    input wire dorpc_req_type i_REQ,
    input wire logic i_FAULT,
    input wire logic i_DOUT,
    output logic o_REQ_READY,
    output logic o_RD_VALID,
    output logic o_RD_DATA,
    output logic o_INIT_DONE,
    output logic o_RAS_N,
    output logic o_CAS_N,
    output logic o_WE_N,
    output logic o_CS_N,
    output logic [HALF_W-1:0] o_ADDR,
    output logic o_DIN
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ROW = 6'h02,
        ST_COL = 6'h04,
        ST_WAIT = 6'h08,
        ST_END = 6'h10,
        ST_REF = 6'h20
    } dorpc_state_type;
    dorpc_state_type st_q, st_d;
    dorpc_pins_type pin_q, pin_d;
    dorpc_req_type req_q, req_d;
    logic [5:0] rrow_q, rrow_d;        // Refresh row pointer
    logic ref_due_q, ref_due_d;        // Refresh request pending
    logic [21:0] gap_q, gap_d;         // Row refresh spacing timer
    logic [3:0] warm_q, warm_d;        // Warm-up refresh count
    logic init_q, init_d;              // Warm-up finished
    logic rdv_q, rdv_d;
    logic rdd_q, rdd_d;
    logic rdy_q, rdy_d;
    logic cnt_clr;
    logic ph_done;
    logic [7:0] ph_cnt;
    logic [7:0] ph_last;
    logic [5:0] pcol_q, pcol_d;        // Columns used in open page
    localparam logic [21:0] GAP_LAST = 22'(ROW_GAP_CYC - 1);
    // Phase timer
    dorpc_count #(.W(8)) u_ph (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_clr(cnt_clr),
        .i_en(1'b1),
        .i_last(ph_last),
        .o_done(ph_done),
        .o_cnt(ph_cnt)
    );
    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        pin_d = pin_q;
        req_d = req_q;
        rrow_d = rrow_q;
        ref_due_d = ref_due_q;
        gap_d = gap_q + 22'h000001;
        warm_d = warm_q;
        init_d = init_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        rdy_d = 1'b0;
        pcol_d = pcol_q;
        cnt_clr = 1'b0;
        ph_last = PHASE_LAST;
        if (gap_q == GAP_LAST) begin
            gap_d = '0;
            ref_due_d = 1'b1;
        end
        case (st_q)
            ST_IDLE: begin
                pin_d.ras_n = 1'b1;
                pin_d.cas_n = 1'b1;
                pin_d.we_n = 1'b1;
                pin_d.cs_n = 1'b1;
                cnt_clr = 1'b1;
                if (ref_due_q || !init_q) begin
                    pin_d.addr = rrow_q;
                    st_d = ST_REF;
                end else if (i_REQ_VALID && !i_FAULT) begin
                    rdy_d = 1'b1;
                    req_d = i_REQ;
                    pin_d.addr = i_REQ.addr[ADDR_W-1:HALF_W];
                    st_d = ST_ROW;
                end
            end
            ST_REF: begin
                pin_d.ras_n = ph_cnt[3] ? 1'b1 : 1'b0;
                ph_last = REF_LAST;
                if (ph_done) begin
                    pin_d.ras_n = 1'b1;
                    // New spacing tick in the same cycle wins over clear
                    ref_due_d = (gap_q == GAP_LAST);
                    rrow_d = rrow_q + 6'h01;
                    if (!init_q) begin
                        warm_d = warm_q + 4'h1;
                        init_d = (warm_q == WARM_LAST);
                    end
                    cnt_clr = 1'b1;
                    st_d = ST_END;
                end
            end
            ST_ROW: begin
                // Row strobe latches and refreshes row
                pin_d.ras_n = 1'b0;
                if (ph_done) begin
                    pin_d.addr = req_q.addr[HALF_W-1:0];
                    pin_d.cs_n = ~req_q.sel;
                    // Early write data ahead of strobe
                    pin_d.we_n = ~req_q.we;
                    pin_d.din = req_q.wdata;
                    cnt_clr = 1'b1;
                    pcol_d = '0;
                    st_d = ST_COL;
                end
            end
            ST_COL: begin
                pin_d.cas_n = 1'b0;
                cnt_clr = 1'b1;
                st_d = ST_WAIT;
            end
            ST_WAIT: begin
                ph_last = ACC_LAST;
                if (ph_done) begin
                    if (!req_q.we) begin
                        rdv_d = 1'b1;
                        rdd_d = i_DOUT;
                    end
                    pin_d.cas_n = 1'b1;
                    pin_d.we_n = 1'b1;
                    cnt_clr = 1'b1;
                    if (req_q.page && i_REQ_VALID && !i_FAULT &&
                        !ref_due_q && (pcol_q != ROW_LAST) &&
                        (i_REQ.addr[ADDR_W-1:HALF_W] ==
                         req_q.addr[ADDR_W-1:HALF_W])) begin
                        rdy_d = 1'b1;
                        req_d = i_REQ;
                        pcol_d = pcol_q + 6'h01;
                        pin_d.addr = i_REQ.addr[HALF_W-1:0];
                        pin_d.cs_n = ~i_REQ.sel;
                        pin_d.we_n = ~i_REQ.we;
                        pin_d.din = i_REQ.wdata;
                        st_d = ST_COL;
                    end else begin
                        pin_d.ras_n = 1'b1;
                        st_d = ST_END;
                    end
                end
            end
            ST_END: begin
                // Precharge before next row strobe
                pin_d.cs_n = 1'b1;
                if (ph_done) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // Fault forces strobes and data inactive
        if (i_FAULT) begin
            pin_d.ras_n = 1'b1;
            pin_d.cas_n = 1'b1;
            pin_d.we_n = 1'b1;
            pin_d.din = 1'b0;
            rdy_d = 1'b0;
            if (st_q != ST_IDLE) begin
                cnt_clr = 1'b1;
                st_d = ST_END;
            end
        end
    end
    // Sequencer registers
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            st_q <= ST_IDLE;
            pin_q <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cs_n: 1'b1,
                       addr: '0, din: 1'b0};
            req_q <= '0;
            rrow_q <= '0;
            ref_due_q <= 1'b0;
            gap_q <= '0;
            warm_q <= '0;
            init_q <= 1'b0;
            rdv_q <= 1'b0;
            rdd_q <= 1'b0;
            rdy_q <= 1'b0;
            pcol_q <= '0;
        end else begin
            st_q <= st_d;
            pin_q <= pin_d;
            req_q <= req_d;
            rrow_q <= rrow_d;
            ref_due_q <= ref_due_d;
            gap_q <= gap_d;
            warm_q <= warm_d;
            init_q <= init_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
            rdy_q <= rdy_d;
            pcol_q <= pcol_d;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_RAS_N = pin_q.ras_n;
    assign o_CAS_N = pin_q.cas_n;
    assign o_WE_N = pin_q.we_n;
    assign o_CS_N = pin_q.cs_n;
    assign o_ADDR = pin_q.addr;
    assign o_DIN = pin_q.din;
    assign o_REQ_READY = rdy_q;
    assign o_RD_VALID = rdv_q;
    assign o_RD_DATA = rdd_q;
    assign o_INIT_DONE = init_q;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ref_cas_high;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (st_q == ST_REF) |-> (o_CAS_N && o_CS_N);
    endproperty
    a_ref_cas_high: assert property (p_ref_cas_high)
        else $error("Column strobe or select active in refresh");
    property p_read_we_high;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (!o_CAS_N && !req_q.we) |-> o_WE_N;
    endproperty
    a_read_we_high: assert property (p_read_we_high)
        else $error("Write low during read column strobe");
    property p_fault_off;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        i_FAULT |=> (o_RAS_N && o_CAS_N && !o_DIN);
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("Strobes not forced off under fault");
    property p_no_req_before_init;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        !o_INIT_DONE |-> !o_REQ_READY;
    endproperty
    a_no_req_before_init: assert property (p_no_req_before_init)
        else $error("Access accepted before warm-up");
    property p_ref_bound;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (ref_due_q && o_INIT_DONE) |-> ##[1:80] !ref_due_q;
    endproperty
    a_ref_bound: assert property (p_ref_bound)
        else $error("Refresh not served in time");
    property p_cas_after_ras;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $fell(o_CAS_N) |-> !o_RAS_N;
    endproperty
    a_cas_after_ras: assert property (p_cas_after_ras)
        else $error("Column strobe without row strobe");
    property p_sel_pin;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        $fell(o_CAS_N) |-> (o_CS_N == !req_q.sel);
    endproperty
    a_sel_pin: assert property (p_sel_pin)
        else $error("Chip select does not match request");
    // Columns strobed under the present row strobe
    logic [6:0] ncas_q, ncas_d;
    // Next column tally, cleared while row strobe is high
    always_comb begin
        ncas_d = ncas_q;
        if (o_RAS_N) begin
            ncas_d = '0;
        end else if (st_q == ST_COL) begin
            ncas_d = ncas_q + 7'h01;
        end
    end
    // Column tally register
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ncas_q <= '0;
        end else begin
            ncas_q <= ncas_d;
        end
    end
    property p_page_limit;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (st_q == ST_COL) |-> (ncas_q < 7'(PAGE_COLS));
    endproperty
    a_page_limit: assert property (p_page_limit)
        else $error("Page exceeds column count");
    property p_rd_latency;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ($fell(o_CAS_N) && !req_q.we) |-> ##14 o_RD_VALID;
    endproperty
    a_rd_latency: assert property (p_rd_latency)
        else $error("Read data not returned after access time");
    c_read: cover property (@(posedge I_CLK) o_RD_VALID);
    c_page: cover property (@(posedge I_CLK) (st_q == ST_WAIT) ##1
        (st_q == ST_COL));
    c_refresh: cover property (@(posedge I_CLK) $rose(ref_due_q));
    c_init: cover property (@(posedge I_CLK) $rose(o_INIT_DONE));
endmodule : dorpc_ctrl
`default_nettype wire

// >>> verification/dorpc_mem.sv
// Behavioural 4096 x 1 dynamic memory facing the strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module dorpc_mem
    import dorpc_pkg::*;
#(
    parameter int ACC_NS = ACCESS_NS
) (
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_cs_n,
    input wire logic [HALF_W-1:0] i_addr,
    input wire logic i_din,
    output logic o_dout
);
    logic mem [0:4095]; // Cell array
    logic [HALF_W-1:0] row_q; // Latched row half
    logic [ADDR_W-1:0] a_q; // Latched cell address
    logic sel_q; // Selection of current column cycle
    logic drv_q; // Output buffer on
    logic val_q; // Output latch
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 1'b0;
        sel_q = 1'b0;
        drv_q = 1'b0;
        val_q = 1'b0;
    end
    always @(negedge i_ras_n) row_q = i_addr;
    // Column fall: float, select, write, schedule output
    always @(negedge i_cas_n) begin
        drv_q = 1'b0;
        sel_q = !i_ras_n && !i_cs_n;
        a_q = {row_q, i_addr};
        if (sel_q && !i_we_n) mem[a_q] = i_din;
        val_q <= #(ACC_NS) mem[a_q];
        drv_q <= #(ACC_NS) sel_q;
    end
    // delayed write latches at write fall
    always @(negedge i_we_n) begin
        // Let strobes that move in the same step settle first
        #1;
        if (!i_ras_n && !i_cas_n && !i_we_n && sel_q) mem[a_q] = i_din;
    end
    // output moves only on column events
    assign o_dout = drv_q ? val_q : ~val_q;
endmodule : dorpc_mem
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the strobe sequencer
`timescale 1ns/10ps
`default_nettype none
module tb
    import dorpc_pkg::*;
;
    logic clk, rst, vld, flt; // Bench-driven inputs
    dorpc_req_type rq; // Request carrier
    wire logic dout; // Memory output
    logic rdy, rv, rd, ini, ras_n, cas_n, we_n, cs_n, din;
    logic [HALF_W-1:0] addr;
    int n_fail = 0;
    int n_checks = 0;
    int cyc, t_cas, n_rf, ref_m[4096]; // Monitor and reference memory
    logic ras_p, cas_p, ini_p, rf, rdm;
    dorpc_req_type cur, pin_q[$]; // Taken requests awaiting column
    logic rd_q[$]; // Expected read data
    logic [ADDR_W-1:0] pool[8]; // Address pool
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    dorpc_ctrl dorpc_ctrl_i (
        .I_CLK(clk), .I_SYS_RST(rst), .i_REQ_VALID(vld), .i_REQ(rq),
        .i_FAULT(flt), .i_DOUT(dout), .o_REQ_READY(rdy), .o_RD_VALID(rv),
        .o_RD_DATA(rd), .o_INIT_DONE(ini), .o_RAS_N(ras_n), .o_CAS_N(cas_n),
        .o_WE_N(we_n), .o_CS_N(cs_n), .o_ADDR(addr), .o_DIN(din)
    );
    dorpc_mem dorpc_mem_i (
        .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_cs_n(cs_n),
        .i_addr(addr), .i_din(din), .o_dout(dout)
    );
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Present one request, hold until taken, update reference
    task automatic req(input logic we, input logic sel, input logic pg,
            input logic [ADDR_W-1:0] a, input logic wd);
        int n;
        @(posedge clk);
        rq <= '{we: we, sel: sel, page: pg, addr: a, wdata: wd};
        vld <= 1'b1;
        if (we && sel) ref_m[a] = wd;
        if (!we) rd_q.push_back(1'(ref_m[a]));
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 3000);
        chk(rdy, 1'b1);
        vld <= 1'b0;
    endtask : req
    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    initial begin
        #(CLK_PERIOD_NS * 60000);
        n_fail++;
        summarize();
    end
    // ------------------------------------------------------------
    // Pin monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (rst) begin
            n_rf = 0;
            ras_p = 1'b1;
            cas_p = 1'b1;
            ini_p = 1'b0;
            rf = 1'b0;
            rdm = 1'b0;
        end else begin
            // Row fall without a taken request is a refresh
            if (ras_p === 1'b1 && ras_n === 1'b0 && pin_q.size() == 0) begin
                rf = 1'b1;
                n_rf++;
            end
            if (ras_n === 1'b1) rf = 1'b0;
            if (rf) chk({cas_n, cs_n}, 2'b11);
            // Taken request: new row or page column
            if (rdy === 1'b1) begin
                pin_q.push_back(rq);
                if (ras_p === 1'b1) chk(addr, rq.addr[11:6]);
                else chk({ras_n, rq.addr[11:6]}, {1'b0, cur.addr[11:6]});
            end
            // Column fall carries the column half and controls
            if (cas_p === 1'b1 && cas_n === 1'b0) begin
                chk(pin_q.size(), 1);
                if (pin_q.size() != 0) cur = pin_q.pop_front();
                chk(addr, cur.addr[5:0]);
                chk(cs_n, !cur.sel);
                chk(we_n, !cur.we);
                if (cur.we) chk(din, cur.wdata);
                rdm = !cur.we;
                t_cas = cyc;
            end
            if (cas_n === 1'b1) rdm = 1'b0;
            if (rdm) chk(we_n, 1'b1);
            // Read result against reference
            if (rv === 1'b1) begin
                chk(cyc - t_cas, ACCESS_CYC + 1);
                chk(rd_q.size() != 0, 1'b1);
                if (rd_q.size() != 0) chk(rd, rd_q.pop_front());
            end
            if (ini === 1'b1 && ini_p !== 1'b1) chk(n_rf, 8);
            ras_p = ras_n;
            cas_p = cas_n;
            ini_p = ini;
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int s, n;
        logic we, sel;
        logic [ADDR_W-1:0] a;
        rst = 1'b1;
        vld = 1'b0;
        flt = 1'b0;
        rq = '0;
        void'($urandom(32'h2586));
        for (int i = 0; i < 8; i++) pool[i] = ADDR_W'($urandom);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Random single cycles over a small address pool
        for (int i = 0; i < 24; i++) begin
            we = 1'($urandom % 2);
            sel = we ? 1'($urandom % 2) : 1'b1;
            req(we, sel, 1'b0, pool[$urandom % 8], 1'($urandom % 2));
        end
        // Page burst in one row, first column deselected
        a = pool[0];
        for (int i = 0; i < 10; i++) begin
            we = (i == 0) ? 1'b1 : 1'($urandom % 2);
            sel = (i == 0) ? 1'b0 : (we ? 1'($urandom % 2) : 1'b1);
            req(we, sel, i < 9, {a[11:6], 6'($urandom)}, 1'($urandom % 2));
        end
        repeat (40) @(posedge clk);
        chk(rd_q.size(), 0);
        // Periodic refresh arrives within 32000 cycles
        s = n_rf;
        n = 0;
        while (n_rf == s && n < 32000) begin
            @(posedge clk);
            n++;
        end
        chk(n_rf > s, 1'b1);
        // Supply fault aborts and refuses requests
        req(1'b1, 1'b0, 1'b0, pool[1], 1'b0);
        repeat (3) @(posedge clk);
        flt <= 1'b1;
        repeat (6) @(posedge clk);
        chk({ras_n, we_n}, 2'b11);
        vld <= 1'b1;
        repeat (30) begin
            @(posedge clk);
            chk(rdy, 1'b0);
        end
        vld <= 1'b0;
        flt <= 1'b0;
        pin_q.delete();
        summarize();
    end
endmodule : tb
`default_nettype wire
